/* rtl/bsau_arith_unit.sv */
// Overview of operation
// - Add adds accumulator and stack level one; sum goes to accumulator.
// - Every binary stack operation pops level one; deeper levels move up.
// - Zero flag set when the result in the accumulator is zero.
// - Carry16 flag set on carry out of bit 15 of an add.
// - Carry32 flag set on carry out of bit 31 of an add.
// - Negative flag follows the result's most significant bit.
// - Sign-error flag set on two's-complement overflow of add or subtract.
// - Subtract takes stack level one from the accumulator.
// - Borrow16 flag set when the low halves need a borrow.
// - Borrow32 flag set when the full subtract needs a borrow.
// - Multiply low halves into a 32-bit product; only zero and negative change.
// - A flag keeps its value until an operation affecting it updates it.
// - A load pushes the old accumulator onto stack level one.
// - Load-double fills accumulator, lower word giving the low half.
// - Store-double copies low and high half out in the same cycle; accumulator unchanged.
//
// The register offsets and the APB slave port are this design's own decisions.
module bsau_arith_unit #(
  parameter int STACK_DEPTH = bsau_pkg::STACK_DEPTH
) (
  input  wire logic                            ref_clk,
  input  wire logic                            rst_b,
  input  wire logic                            clkEn,
  input  wire logic [bsau_pkg::APB_ADDR_W-1:0] paddr,
  input  wire logic                            psel,
  input  wire logic                            penable,
  input  wire logic                            pwrite,
  input  wire logic [bsau_pkg::DATA_W-1:0]     pwdata,
  output logic      [bsau_pkg::DATA_W-1:0]     prdata,
  output logic                                 pready,
  output logic                                 pslverr,
  output logic                                 irq,
  output logic                                 zeroResultFlag,
  output logic                                 borrow16Flag,
  output logic                                 borrow32Flag,
  output logic                                 carry16Flag,
  output logic                                 carry32Flag,
  output logic                                 negativeResultFlag,
  output logic                                 signErrorFlag
);

  localparam int DW = bsau_pkg::DATA_W;
  localparam int HW = bsau_pkg::HALF_W;
  localparam int NF = bsau_pkg::NUM_FLAGS;
  localparam int OW = bsau_pkg::OP_W;

  typedef struct packed {
    logic [DW-1:0] acc;
    logic [HW-1:0] dataLo;
    logic [HW-1:0] dataHi;
    logic [HW-1:0] storeLo;
    logic [HW-1:0] storeHi;
    logic [NF-1:0] flags;
    logic [NF-1:0] irqStatus;
    logic [NF-1:0] irqMask;
    logic [OW-1:0] lastOp;
    logic [DW-1:0] rdData;
    logic          ready;
    logic          slvErr;
    logic          irqOut;
  } bsau_state_type;

  localparam bsau_state_type RESET_STATE = '0;

  // ==========================================================================
  // Reset release
  // The reset asserts at once but releases on the clock, so no flop leaves
  // reset in a different cycle from its neighbours.
  logic [1:0] rstPipe_reg;
  logic       rstSyncB;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rstPipe_reg <= 2'h0;
    end else begin
      rstPipe_reg <= {rstPipe_reg[0], 1'b1};
    end
  end

  assign rstSyncB = rstPipe_reg[1];

  // ==========================================================================
  // Arithmetic
  function automatic bsau_pkg::bsau_alu_type aluExec(input logic [OW-1:0] op,
                                                    input logic [DW-1:0] a,
                                                    input logic [DW-1:0] b);
    logic [DW:0]           wide;
    logic [HW:0]           low;
    bsau_pkg::bsau_alu_type o;
    o    = '0;
    wide = '0;
    low  = '0;
    case (op)
      bsau_pkg::OP_ADD: begin
        wide = {1'b0, a} + {1'b0, b};
        low  = {1'b0, a[HW-1:0]} + {1'b0, b[HW-1:0]};
        o.result = wide[DW-1:0];
        o.flags[bsau_pkg::FLAG_CAR16] = low[HW];
        o.flags[bsau_pkg::FLAG_CAR32] = wide[DW];
        o.flags[bsau_pkg::FLAG_SIGN] = (a[DW-1] == b[DW-1]) && (wide[DW-1] != a[DW-1]);
        o.affect = bsau_pkg::AFFECT_ADD;
      end
      bsau_pkg::OP_SUB: begin
        wide = {1'b0, a} - {1'b0, b};
        low  = {1'b0, a[HW-1:0]} - {1'b0, b[HW-1:0]};
        o.result = wide[DW-1:0];
        o.flags[bsau_pkg::FLAG_BOR16] = low[HW];
        o.flags[bsau_pkg::FLAG_BOR32] = wide[DW];
        o.flags[bsau_pkg::FLAG_SIGN] = (a[DW-1] != b[DW-1]) && (wide[DW-1] != a[DW-1]);
        o.affect = bsau_pkg::AFFECT_SUB;
      end
      bsau_pkg::OP_MUL: begin
        o.result = {{HW{1'b0}}, a[HW-1:0]} * {{HW{1'b0}}, b[HW-1:0]};
        o.affect = bsau_pkg::AFFECT_MUL;
      end
      default: begin
        o.affect = '0;
      end
    endcase
    o.flags[bsau_pkg::FLAG_ZERO] = (o.result == '0);
    o.flags[bsau_pkg::FLAG_NEG]  = o.result[DW-1];
    return o;
  endfunction : aluExec

  // ==========================================================================
  // State update
  bsau_state_type         stReg;
  bsau_state_type         stNext;
  bsau_pkg::bsau_alu_type aluOut;
  logic [DW-1:0]          stackTop;
  logic [OW-1:0]          wrOp;
  logic                   accessDone;
  logic                   cmdWrite;
  logic                   stackPush;
  logic                   stackPop;
  logic [NF-1:0]          events;
  logic [NF-1:0]          clearBits;
  logic [DW-1:0]          rdValue;
  logic                   addrHit;

  assign wrOp = pwdata[OW-1:0];

  always_comb begin
    stNext     = stReg;
    aluOut     = aluExec(wrOp, stReg.acc, stackTop);
    accessDone = psel && penable && stReg.ready;
    cmdWrite   = accessDone && pwrite && (paddr == bsau_pkg::ADDR_CMD);
    stackPush  = 1'b0;
    stackPop   = 1'b0;
    events     = '0;
    clearBits  = '0;
    addrHit    = 1'b1;
    rdValue    = '0;
    unique case (paddr)
      bsau_pkg::ADDR_CMD:        rdValue = {{(DW-OW){1'b0}}, stReg.lastOp};
      bsau_pkg::ADDR_DATA_LO:    rdValue = {{HW{1'b0}}, stReg.dataLo};
      bsau_pkg::ADDR_DATA_HI:    rdValue = {{HW{1'b0}}, stReg.dataHi};
      bsau_pkg::ADDR_ACC:        rdValue = stReg.acc;
      bsau_pkg::ADDR_STACK_TOP:  rdValue = stackTop;
      bsau_pkg::ADDR_STORE_LO:   rdValue = {{HW{1'b0}}, stReg.storeLo};
      bsau_pkg::ADDR_STORE_HI:   rdValue = {{HW{1'b0}}, stReg.storeHi};
      bsau_pkg::ADDR_FLAGS:      rdValue = {{(DW-NF){1'b0}}, stReg.flags};
      bsau_pkg::ADDR_IRQ_STATUS: rdValue = {{(DW-NF){1'b0}}, stReg.irqStatus};
      bsau_pkg::ADDR_IRQ_MASK:   rdValue = {{(DW-NF){1'b0}}, stReg.irqMask};
      default:                   addrHit = 1'b0;
    endcase
    // One wait state: data and the error are registered in the first access
    // cycle and presented with ready in the second.
    stNext.ready  = psel && penable && !stReg.ready;
    stNext.slvErr = psel && penable && !stReg.ready && !addrHit;
    stNext.rdData = (psel && penable && !stReg.ready && !pwrite) ? rdValue : '0;
    if (accessDone && pwrite && addrHit) begin
      unique case (paddr)
        bsau_pkg::ADDR_DATA_LO:    stNext.dataLo = pwdata[HW-1:0];
        bsau_pkg::ADDR_DATA_HI:    stNext.dataHi = pwdata[HW-1:0];
        bsau_pkg::ADDR_IRQ_STATUS: clearBits = pwdata[NF-1:0];
        bsau_pkg::ADDR_IRQ_MASK:   stNext.irqMask = pwdata[NF-1:0];
        default:                   stNext.lastOp = stReg.lastOp;
      endcase
    end
    if (cmdWrite) begin
      stNext.lastOp = wrOp;
      case (wrOp)
        bsau_pkg::OP_LOAD: begin
          stackPush = 1'b1;
          stNext.acc = {{HW{1'b0}}, stReg.dataLo};
        end
        bsau_pkg::OP_LOAD_DOUBLE: begin
          stackPush = 1'b1;
          stNext.acc = {stReg.dataHi, stReg.dataLo};
        end
        bsau_pkg::OP_STORE_DOUBLE: begin
          stNext.storeLo = stReg.acc[HW-1:0];
          stNext.storeHi = stReg.acc[DW-1:HW];
        end
        bsau_pkg::OP_ADD, bsau_pkg::OP_SUB, bsau_pkg::OP_MUL: begin
          stackPop = 1'b1;
          stNext.acc = aluOut.result;
          stNext.flags = (stReg.flags & ~aluOut.affect)
                       | (aluOut.flags & aluOut.affect);
          events = aluOut.flags & aluOut.affect;
        end
        default: begin
          stNext.lastOp = wrOp;
        end
      endcase
    end
    // A flag raised in the same cycle as its clear survives the clear.
    stNext.irqStatus = (stReg.irqStatus & ~clearBits) | events;
    stNext.irqOut    = |(stNext.irqStatus & stNext.irqMask);
  end

  always_ff @(posedge ref_clk or negedge rstSyncB) begin
    if (!rstSyncB) begin
      stReg <= RESET_STATE;
    end else if (clkEn) begin
      stReg <= stNext;
    end
  end

  bsau_stack #(
    .DEPTH (STACK_DEPTH),
    .WIDTH (DW)
  ) u_stack (
    .clk      (ref_clk),
    .rstB     (rstSyncB),
    .clkEn    (clkEn),
    .push     (stackPush),
    .pop      (stackPop),
    .pushData (stReg.acc),
    .top      (stackTop)
  );

  assign prdata             = stReg.rdData;
  assign pready             = stReg.ready;
  assign pslverr            = stReg.slvErr;
  assign irq                = stReg.irqOut;
  assign zeroResultFlag     = stReg.flags[bsau_pkg::FLAG_ZERO];
  assign borrow16Flag       = stReg.flags[bsau_pkg::FLAG_BOR16];
  assign borrow32Flag       = stReg.flags[bsau_pkg::FLAG_BOR32];
  assign carry16Flag        = stReg.flags[bsau_pkg::FLAG_CAR16];
  assign carry32Flag        = stReg.flags[bsau_pkg::FLAG_CAR32];
  assign negativeResultFlag = stReg.flags[bsau_pkg::FLAG_NEG];
  assign signErrorFlag      = stReg.flags[bsau_pkg::FLAG_SIGN];

  // ==========================================================================
  // Checks
  sequence seqCmd(logic [OW-1:0] opc);
    clkEn && cmdWrite && (wrOp == opc);
  endsequence

  sequence seqArith;
    seqCmd(bsau_pkg::OP_ADD) or seqCmd(bsau_pkg::OP_SUB) or seqCmd(bsau_pkg::OP_MUL);
  endsequence

  chk_add_sum: assert property (@(posedge ref_clk) disable iff (!rstSyncB)
    seqCmd(bsau_pkg::OP_ADD) |=> stReg.acc == $past(stReg.acc) + $past(stackTop))
    else $error("Add result is wrong.");

  chk_sub_diff: assert property (@(posedge ref_clk) disable iff (!rstSyncB)
    seqCmd(bsau_pkg::OP_SUB) |=> stReg.acc == $past(stReg.acc) - $past(stackTop))
    else $error("Subtract result is wrong.");

  chk_mul_product: assert property (@(posedge ref_clk) disable iff (!rstSyncB)
    seqCmd(bsau_pkg::OP_MUL) |=> stReg.acc == $past(stReg.acc[HW-1:0]) * $past(stackTop[HW-1:0])
      && $stable(stReg.flags[bsau_pkg::FLAG_CAR32:bsau_pkg::FLAG_BOR16])
      && $stable(signErrorFlag))
    else $error("Multiply result or untouched flags are wrong.");

  chk_zero_neg: assert property (@(posedge ref_clk) disable iff (!rstSyncB)
    seqArith |=> zeroResultFlag == (stReg.acc == '0) && negativeResultFlag == stReg.acc[DW-1])
    else $error("Zero or negative flag disagrees with the accumulator.");

  chk_add_carries: assert property (@(posedge ref_clk) disable iff (!rstSyncB)
    seqCmd(bsau_pkg::OP_ADD) |=>
      carry16Flag == ($past(stReg.acc[HW-1:0]) > ~$past(stackTop[HW-1:0]))
      && carry32Flag == ($past(stReg.acc) > ~$past(stackTop)))
    else $error("Add carry flags are wrong.");

  chk_sub_borrows: assert property (@(posedge ref_clk) disable iff (!rstSyncB)
    seqCmd(bsau_pkg::OP_SUB) |=>
      borrow16Flag == ($past(stReg.acc[HW-1:0]) < $past(stackTop[HW-1:0]))
      && borrow32Flag == ($past(stReg.acc) < $past(stackTop)))
    else $error("Subtract borrow flags are wrong.");

  chk_add_overflow: assert property (@(posedge ref_clk) disable iff (!rstSyncB)
    seqCmd(bsau_pkg::OP_ADD) |=>
      signErrorFlag == (($past(stReg.acc[DW-1]) == $past(stackTop[DW-1]))
      && (stReg.acc[DW-1] != $past(stReg.acc[DW-1]))))
    else $error("Sign-error flag is wrong after add.");

  chk_sub_overflow: assert property (@(posedge ref_clk) disable iff (!rstSyncB)
    seqCmd(bsau_pkg::OP_SUB) |=>
      signErrorFlag == (($past(stReg.acc[DW-1]) != $past(stackTop[DW-1]))
      && (stReg.acc[DW-1] != $past(stReg.acc[DW-1]))))
    else $error("Sign-error flag is wrong after subtract.");

  chk_add_keeps: assert property (@(posedge ref_clk) disable iff (!rstSyncB)
    seqCmd(bsau_pkg::OP_ADD) |=> $stable(borrow16Flag) && $stable(borrow32Flag))
    else $error("Add changed a borrow flag.");

  chk_sub_keeps: assert property (@(posedge ref_clk) disable iff (!rstSyncB)
    seqCmd(bsau_pkg::OP_SUB) |=> $stable(carry16Flag) && $stable(carry32Flag))
    else $error("Subtract changed a carry flag.");

  chk_load_keeps: assert property (@(posedge ref_clk) disable iff (!rstSyncB)
    seqCmd(bsau_pkg::OP_LOAD) or seqCmd(bsau_pkg::OP_STORE_DOUBLE) |=> $stable(stReg.flags))
    else $error("Flags changed on an operation that does not affect them.");

  chk_load_word: assert property (@(posedge ref_clk) disable iff (!rstSyncB)
    seqCmd(bsau_pkg::OP_LOAD) |=> stReg.acc == {{HW{1'b0}}, $past(stReg.dataLo)}
      && stackTop == $past(stReg.acc))
    else $error("Load did not clear the upper half or push the old value.");

  chk_load_double: assert property (@(posedge ref_clk) disable iff (!rstSyncB)
    seqCmd(bsau_pkg::OP_LOAD_DOUBLE) |=> stReg.acc == {$past(stReg.dataHi), $past(stReg.dataLo)})
    else $error("Load-double halves are wrong.");

  chk_store_double: assert property (@(posedge ref_clk) disable iff (!rstSyncB)
    seqCmd(bsau_pkg::OP_STORE_DOUBLE) |=> {stReg.storeHi, stReg.storeLo} == $past(stReg.acc)
      && $stable(stReg.acc))
    else $error("Store-double copy is wrong or changed the accumulator.");

  sequence seqAccessWait;
    clkEn && psel && penable && !pready;
  endsequence

  chk_ready_wait: assert property (@(posedge ref_clk) disable iff (!rstSyncB)
    seqAccessWait |=> pready)
    else $error("Access phase was not answered after one wait state.");

  chk_ready_pulse: assert property (@(posedge ref_clk) disable iff (!rstSyncB)
    clkEn && pready |=> !pready)
    else $error("Ready stood for more than one cycle.");

  // An event must set its status bit in the cycle after its command.
  chk_status_set: assert property (@(posedge ref_clk) disable iff (!rstSyncB)
    clkEn && cmdWrite |=> (stReg.irqStatus & $past(events)) == $past(events))
    else $error("An event did not set its status bit.");

  chk_status_clear: assert property (@(posedge ref_clk) disable iff (!rstSyncB)
    clkEn && accessDone && pwrite && (paddr == bsau_pkg::ADDR_IRQ_STATUS)
    |=> (stReg.irqStatus & $past(pwdata[NF-1:0])) == '0)
    else $error("Writing a one did not clear its status bit.");

endmodule : bsau_arith_unit

/* rtl/bsau_pkg.sv */
package bsau_pkg;

  // ==========================================================================
  // Widths and sizes
  localparam int DATA_W      = 32;
  localparam int HALF_W      = 16;
  localparam int STACK_DEPTH = 8;
  localparam int NUM_FLAGS   = 7;
  localparam int OP_W        = 3;
  localparam int APB_ADDR_W  = 8;

  // ==========================================================================
  // Register byte addresses
  localparam logic [APB_ADDR_W-1:0] ADDR_CMD        = 8'h00;
  localparam logic [APB_ADDR_W-1:0] ADDR_DATA_LO    = 8'h04;
  localparam logic [APB_ADDR_W-1:0] ADDR_DATA_HI    = 8'h08;
  localparam logic [APB_ADDR_W-1:0] ADDR_ACC        = 8'h0C;
  localparam logic [APB_ADDR_W-1:0] ADDR_STACK_TOP  = 8'h10;
  localparam logic [APB_ADDR_W-1:0] ADDR_STORE_LO   = 8'h14;
  localparam logic [APB_ADDR_W-1:0] ADDR_STORE_HI   = 8'h18;
  localparam logic [APB_ADDR_W-1:0] ADDR_FLAGS      = 8'h1C;
  localparam logic [APB_ADDR_W-1:0] ADDR_IRQ_STATUS = 8'h20;
  localparam logic [APB_ADDR_W-1:0] ADDR_IRQ_MASK   = 8'h24;

  // ==========================================================================
  // Operation codes written to the command register
  localparam logic [OP_W-1:0] OP_NOP          = 3'h0;
  localparam logic [OP_W-1:0] OP_LOAD         = 3'h1;
  localparam logic [OP_W-1:0] OP_LOAD_DOUBLE  = 3'h2;
  localparam logic [OP_W-1:0] OP_STORE_DOUBLE = 3'h3;
  localparam logic [OP_W-1:0] OP_ADD          = 3'h4;
  localparam logic [OP_W-1:0] OP_SUB          = 3'h5;
  localparam logic [OP_W-1:0] OP_MUL          = 3'h6;

  // ==========================================================================
  // Flag bit positions and the flags each operation updates
  localparam int FLAG_ZERO   = 0;
  localparam int FLAG_BOR16  = 1;
  localparam int FLAG_BOR32  = 2;
  localparam int FLAG_CAR16  = 3;
  localparam int FLAG_CAR32  = 4;
  localparam int FLAG_NEG    = 5;
  localparam int FLAG_SIGN   = 6;
  localparam logic [NUM_FLAGS-1:0] AFFECT_ADD = 7'h79;
  localparam logic [NUM_FLAGS-1:0] AFFECT_SUB = 7'h67;
  localparam logic [NUM_FLAGS-1:0] AFFECT_MUL = 7'h21;

  typedef struct packed {
    logic [DATA_W-1:0]    result;
    logic [NUM_FLAGS-1:0] flags;
    logic [NUM_FLAGS-1:0] affect;
  } bsau_alu_type;

endpackage : bsau_pkg

/* rtl/bsau_stack.sv */
module bsau_stack #(
  parameter int DEPTH = bsau_pkg::STACK_DEPTH,
  parameter int WIDTH = bsau_pkg::DATA_W
) (
  input  wire logic             clk,
  input  wire logic             rstB,
  input  wire logic             clkEn,
  input  wire logic             push,
  input  wire logic             pop,
  input  wire logic [WIDTH-1:0] pushData,
  output logic      [WIDTH-1:0] top
);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] level;
  } bsau_stack_type;

  bsau_stack_type stReg;
  bsau_stack_type stNext;

  // ==========================================================================
  // Shift logic; index 0 is the first level.
  always_comb begin
    stNext = stReg;
    if (push) begin
      for (int i = DEPTH - 1; i > 0; i--) begin
        stNext.level[i] = stReg.level[i-1];
      end
      stNext.level[0] = pushData;
    end else if (pop) begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        stNext.level[i] = stReg.level[i+1];
      end
      stNext.level[DEPTH-1] = '0;
    end
  end

  always_ff @(posedge clk or negedge rstB) begin
    if (!rstB) begin
      stReg <= '0;
    end else if (clkEn) begin
      stReg <= stNext;
    end
  end

  assign top = stReg.level[0];

  // ==========================================================================
  // Checks
  chk_pop_shift_up: assert property (@(posedge clk) disable iff (!rstB)
    clkEn && pop && !push |=> stReg.level[0] == $past(stReg.level[1]))
    else $error("Pop did not move level two up to level one.");

  chk_pop_zero_fill: assert property (@(posedge clk) disable iff (!rstB)
    clkEn && pop && !push |=> stReg.level[DEPTH-1] == '0)
    else $error("Pop did not clear the deepest level.");

  chk_push_drop_deep: assert property (@(posedge clk) disable iff (!rstB)
    clkEn && push |=> stReg.level[DEPTH-1] == $past(stReg.level[DEPTH-2]))
    else $error("Push did not shift the deep levels down.");

endmodule : bsau_stack

/* tb/bsau_seq_model.sv */
module bsau_seq_model (
  input  wire logic        ref_clk,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  output logic      [7:0]  paddr,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [31:0] pwdata
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // Sequencer side of the register bus.
  // The slave latency is not assumed; only the bench watchdog ends a wait.
  initial begin
    paddr   = 8'h00;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    pwdata  = 32'h00000000;
  end

  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] r, output logic e);
    @(posedge ref_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
endmodule : bsau_seq_model

/* tb/binary_stack_arith_unit_bench.sv */
module binary_stack_arith_unit_bench;
  timeunit 1ns;
  timeprecision 1ps;

  logic        ref_clk = 1'b0;
  logic        rst_b   = 1'b0;
  logic        clkEn   = 1'b1;
  logic [7:0]  paddr;
  logic        psel, penable, pwrite, pready, pslverr, irq;
  logic [31:0] pwdata, prdata;
  logic        f0, f1, f2, f3, f4, f5, f6;
  logic [6:0]  flagPorts;
  int          errors = 0;
  int          total_checks = 0;
  logic [31:0] acc, r;
  logic [31:0] stk [8];
  logic [6:0]  flg, sts;
  logic        e;
  logic [31:0] ta [8] = '{32'hFFFFFFFF, 32'h7FFFFFFF, 32'h0000FFFF, 32'h00000000,
                          32'h80000000, 32'h00000005, 32'hABCD0003, 32'h0000FFFF};
  logic [31:0] tb [8] = '{32'h00000001, 32'h00000001, 32'h00000001, 32'h00000001,
                          32'h00000001, 32'h00000005, 32'h00050004, 32'h0000FFFF};
  logic [2:0]  to [8] = '{3'h4, 3'h4, 3'h4, 3'h5, 3'h5, 3'h5, 3'h6, 3'h6};

  assign flagPorts = {f6, f5, f4, f3, f2, f1, f0};

  initial forever #2.5 ref_clk = ~ref_clk;

  bsau_arith_unit bsau_arith_unit_i (
    .ref_clk(ref_clk), .rst_b(rst_b), .clkEn(clkEn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .zeroResultFlag(f0),
    .borrow16Flag(f1), .borrow32Flag(f2), .carry16Flag(f3), .carry32Flag(f4),
    .negativeResultFlag(f5), .signErrorFlag(f6));

  bsau_seq_model bsau_seq_model_i (
    .ref_clk(ref_clk), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata));

  // ==========================================================================
  // Access and comparison helpers
  task cmp(input logic [31:0] got, input logic [31:0] exp, input string m);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask : cmp

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    logic        y;
    bsau_seq_model_i.xfer(1'b1, a, d, x, y);
  endtask : wr

  task rd(input logic [7:0] a, input logic [31:0] exp, input string m);
    bsau_seq_model_i.xfer(1'b0, a, 32'h00000000, r, e);
    cmp(r, exp, m);
  endtask : rd

  // ==========================================================================
  // Reference model of accumulator, stack and flags
  task ld(input logic [31:0] v, input logic dbl);
    wr(bsau_pkg::ADDR_DATA_LO, {16'h0000, v[15:0]});
    wr(bsau_pkg::ADDR_DATA_HI, {16'h0000, v[31:16]});
    wr(bsau_pkg::ADDR_CMD, dbl ? 32'h00000002 : 32'h00000001);
    for (int i = 7; i > 0; i--) stk[i] = stk[i-1];
    stk[0] = acc;
    acc = dbl ? v : {16'h0000, v[15:0]};
  endtask : ld

  task binop(input logic [2:0] op);
    logic [32:0] s;
    logic [16:0] h;
    logic [6:0]  nf, af;
    logic [31:0] b;
    b  = stk[0];
    nf = 7'h00;
    h  = {1'b0, acc[15:0]} + {1'b0, b[15:0]};
    if (op == bsau_pkg::OP_ADD) begin
      s = {1'b0, acc} + {1'b0, b};
      af = bsau_pkg::AFFECT_ADD;
      nf[bsau_pkg::FLAG_CAR16] = h[16];
      nf[bsau_pkg::FLAG_CAR32] = s[32];
      nf[bsau_pkg::FLAG_SIGN] = (acc[31] == b[31]) && (s[31] != acc[31]);
    end else if (op == bsau_pkg::OP_SUB) begin
      s = {1'b0, acc} - {1'b0, b};
      af = bsau_pkg::AFFECT_SUB;
      nf[bsau_pkg::FLAG_BOR16] = acc[15:0] < b[15:0];
      nf[bsau_pkg::FLAG_BOR32] = acc < b;
      nf[bsau_pkg::FLAG_SIGN] = (acc[31] != b[31]) && (s[31] != acc[31]);
    end else begin
      s = {17'h00000, acc[15:0]} * {17'h00000, b[15:0]};
      af = bsau_pkg::AFFECT_MUL;
    end
    nf[bsau_pkg::FLAG_ZERO] = (s[31:0] == 32'h00000000);
    nf[bsau_pkg::FLAG_NEG] = s[31];
    wr(bsau_pkg::ADDR_CMD, {29'h00000000, op});
    acc = s[31:0];
    flg = (flg & ~af) | (nf & af);
    sts = sts | (nf & af);
    for (int i = 0; i < 7; i++) stk[i] = stk[i+1];
    stk[7] = 32'h00000000;
  endtask : binop

  task chk();
    rd(bsau_pkg::ADDR_ACC, acc, "accumulator");
    rd(bsau_pkg::ADDR_STACK_TOP, stk[0], "stack level one");
    rd(bsau_pkg::ADDR_FLAGS, {25'h0000000, flg}, "flag register");
    cmp({25'h0000000, flagPorts}, {25'h0000000, flg}, "flag outputs");
  endtask : chk

  task end_of_test();
    $display("Checks made: %0d, mismatches: %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_of_test

  initial begin
    #20000;
    errors++;
    end_of_test();
  end

  // ==========================================================================
  // Test sequence
  initial begin
    acc = 32'h00000000;
    flg = 7'h00;
    sts = 7'h00;
    foreach (stk[i]) stk[i] = 32'h00000000;
    repeat (6) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge ref_clk);
    chk();
    ld(32'h12345678, 1'b1);
    wr(bsau_pkg::ADDR_CMD, 32'h00000003);
    rd(bsau_pkg::ADDR_STORE_LO, 32'h00005678, "store low");
    rd(bsau_pkg::ADDR_STORE_HI, 32'h00001234, "store high");
    chk();
    ld(32'hABCDFFFF, 1'b0);
    chk();
    for (int k = 0; k < 8; k++) begin
      ld(tb[k], 1'b1);
      ld(ta[k], 1'b1);
      binop(to[k]);
      chk();
    end
    // Overfilling the stack drops the deepest level; later pops refill with zero.
    for (int k = 1; k <= 9; k++) ld(k, 1'b0);
    for (int k = 0; k < 9; k++) begin
      binop(bsau_pkg::OP_ADD);
      chk();
    end
    // Dropping the enable mid-transfer must stretch the access, not lose or repeat it.
    fork
      binop(bsau_pkg::OP_SUB);
      begin
        @(posedge ref_clk);
        clkEn <= 1'b0;
        repeat (3) @(posedge ref_clk);
        clkEn <= 1'b1;
      end
    join
    chk();
    wr(bsau_pkg::ADDR_ACC, 32'h0000DEAD);
    wr(bsau_pkg::ADDR_CMD, 32'h00000007);
    chk();
    rd(bsau_pkg::ADDR_CMD, 32'h00000007, "command readback");
    bsau_seq_model_i.xfer(1'b0, 8'h30, 32'h00000000, r, e);
    cmp({31'h00000000, e}, 32'h00000001, "unmapped error");
    cmp(r, 32'h00000000, "unmapped data");
    rd(bsau_pkg::ADDR_IRQ_STATUS, {25'h0000000, sts}, "event status");
    wr(bsau_pkg::ADDR_IRQ_MASK, 32'h00000000);
    @(posedge ref_clk);
    #1 cmp({31'h00000000, irq}, 32'h00000000, "masked interrupt");
    wr(bsau_pkg::ADDR_IRQ_MASK, 32'h00000020);
    @(posedge ref_clk);
    #1 cmp({31'h00000000, irq}, {31'h00000000, sts[bsau_pkg::FLAG_NEG]}, "interrupt");
    wr(bsau_pkg::ADDR_IRQ_STATUS, 32'h0000007F);
    @(posedge ref_clk);
    #1 cmp({31'h00000000, irq}, 32'h00000000, "cleared interrupt");
    rd(bsau_pkg::ADDR_IRQ_STATUS, 32'h00000000, "cleared status");
    end_of_test();
  end
endmodule : binary_stack_arith_unit_bench
